// *** design/etp_consts.svh ***
// How it works
// - with pulse and single-pulse modes both on, only pulse mode runs.
// - pulse mode blocks capture on input one; input two still captures.
// - counter equal to value one but not value two drives the output pin to level one.
// - counter equal to value two drives the output pin to level two.
// - pulse mode never sets the compare-match flags.
// - pulse mode suppresses the compare interrupt request.
// - pulse mode still raises the interrupt for capture-one events when enabled.
// - the pulse waveform appears on compare output pin one in pulse mode.
// - period and duty follow the two compare values and two match levels.
// - pulse mode sets capture flag one when counter reaches compare value two.
`ifndef ETP_CONSTS_SVH
`define ETP_CONSTS_SVH
`define ETP_CNT_INIT 8'h00
`define ETP_CNT_WIDTH 8
`define ETP_CMP_MAX 8'hFC
`endif

// *** design/etp_pkg.sv ***
package etp_pkg;
  typedef enum logic [1:0] {
    ETP_IDLE = 2'b00,
    ETP_PWM = 2'b01,
    ETP_OPM = 2'b10
  } etp_mode_e;
endpackage : etp_pkg

// *** design/etp_timer_pwm.sv ***
`timescale 1ns/1ps
`include "etp_consts.svh"
module etp_timer_pwm
  import etp_pkg::*;
#(
  parameter int W = `ETP_CNT_WIDTH
)
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic timer_enable_in,
  input wire logic configure_pulse_width_mode_in,
  input wire logic single_pulse_mode_in,
  input wire logic match_one_level_high_in,
  input wire logic match_two_level_high_in,
  input wire logic [W-1:0] compare_value_one_in,
  input wire logic [W-1:0] compare_value_two_in,
  input wire logic capture_input_one_in,
  input wire logic capture_input_two_in,
  input wire logic capture_edge_rising_in,
  input wire logic capture_irq_enable_in,
  input wire logic compare_irq_enable_in,
  input wire logic flag_clear_in,
  output logic compare_output_pin_one_out,
  output logic [W-1:0] counter_out,
  output logic [W-1:0] capture_value_one_out,
  output logic [W-1:0] capture_value_two_out,
  output logic capture_flag_one_out,
  output logic capture_flag_two_out,
  output logic compare_flag_one_out,
  output logic compare_flag_two_out,
  output logic timer_irq_out,
  output logic [1:0] mode_out
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic pin_ff;
  logic nxt_pin;
  logic cap1_in_ff;
  logic cap2_in_ff;
  logic [W-1:0] cap1_val_ff;
  logic [W-1:0] cap2_val_ff;
  logic icf1_ff;
  logic icf2_ff;
  logic ocf1_ff;
  logic ocf2_ff;
  logic irq_ff;
  etp_mode_e mode_ff;
  etp_mode_e nxt_mode;

  // pulse mode overrides single-pulse selection
  wire pwm_on = timer_enable_in & configure_pulse_width_mode_in;
  wire opm_on = timer_enable_in & single_pulse_mode_in & ~configure_pulse_width_mode_in;
  wire match_one = timer_enable_in & (cnt_ff == compare_value_one_in);
  wire match_two = timer_enable_in & (cnt_ff == compare_value_two_in);
  wire wrap = pwm_on & match_two;

  function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
    edge_hit = rising ? (~prev & cur) : (prev & ~cur);
  endfunction : edge_hit

  // the capture-one pin is ignored in pulse and single-pulse modes
  wire cap1_edge = timer_enable_in & ~pwm_on & ~opm_on
    & edge_hit(cap1_in_ff, capture_input_one_in, capture_edge_rising_in);
  wire cap2_edge = timer_enable_in
    & edge_hit(cap2_in_ff, capture_input_two_in, capture_edge_rising_in);
  wire set_icf1 = cap1_edge | wrap;
  wire set_ocf1 = match_one & ~pwm_on;
  wire set_ocf2 = match_two & ~pwm_on;

  assign nxt_cnt = !timer_enable_in ? cnt_ff
    : wrap ? W'(`ETP_CNT_INIT)
    : cnt_ff + {{(W-1){1'b0}}, 1'b1};
  // match two takes priority when both values coincide, as it ends the period
  assign nxt_pin = !pwm_on ? pin_ff
    : match_two ? match_two_level_high_in
    : match_one ? match_one_level_high_in
    : pin_ff;
  assign nxt_mode = pwm_on ? ETP_PWM : opm_on ? ETP_OPM : ETP_IDLE;

  // the set wins over a clear landing in the same cycle
  wire nxt_icf1 = set_icf1 | (icf1_ff & ~flag_clear_in);
  wire nxt_icf2 = cap2_edge | (icf2_ff & ~flag_clear_in);
  wire nxt_ocf1 = set_ocf1 | (ocf1_ff & ~flag_clear_in);
  wire nxt_ocf2 = set_ocf2 | (ocf2_ff & ~flag_clear_in);
  wire cmp_irq = compare_irq_enable_in & ~pwm_on & (nxt_ocf1 | nxt_ocf2);
  wire cap_irq = capture_irq_enable_in & (nxt_icf1 | nxt_icf2);
  wire nxt_irq = cmp_irq | cap_irq;

  // one register per process keeps each reset value beside its flop
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_ff <= W'(`ETP_CNT_INIT);
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_ff <= 1'b0;
    end
    else
    begin
      pin_ff <= nxt_pin;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mode_ff <= ETP_IDLE;
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cap1_in_ff <= 1'b0;
    end
    else
    begin
      cap1_in_ff <= capture_input_one_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cap2_in_ff <= 1'b0;
    end
    else
    begin
      cap2_in_ff <= capture_input_two_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cap1_val_ff <= '0;
    end
    else if (cap1_edge)
    begin
      cap1_val_ff <= cnt_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cap2_val_ff <= '0;
    end
    else if (cap2_edge)
    begin
      cap2_val_ff <= cnt_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      icf1_ff <= 1'b0;
    end
    else
    begin
      icf1_ff <= nxt_icf1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      icf2_ff <= 1'b0;
    end
    else
    begin
      icf2_ff <= nxt_icf2;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ocf1_ff <= 1'b0;
    end
    else
    begin
      ocf1_ff <= nxt_ocf1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ocf2_ff <= 1'b0;
    end
    else
    begin
      ocf2_ff <= nxt_ocf2;
    end
  end

  assign compare_output_pin_one_out = pin_ff;
  assign counter_out = cnt_ff;
  assign capture_value_one_out = cap1_val_ff;
  assign capture_value_two_out = cap2_val_ff;
  assign capture_flag_one_out = icf1_ff;
  assign capture_flag_two_out = icf2_ff;
  assign compare_flag_one_out = ocf1_ff;
  assign compare_flag_two_out = ocf2_ff;
  assign timer_irq_out = irq_ff;
  assign mode_out = mode_ff;
endmodule : etp_timer_pwm

// *** dv/etp_props.sv ***
`timescale 1ns/1ps
module etp_props #(parameter int W = 8) (
  input wire logic sys_clk_in, reset_n_in, timer_enable_in, capture_irq_enable_in,
  input wire logic configure_pulse_width_mode_in, match_one_level_high_in,
  input wire logic match_two_level_high_in, capture_input_two_in, capture_edge_rising_in,
  input wire logic compare_output_pin_one_out, capture_flag_one_out, capture_flag_two_out,
  input wire logic compare_flag_one_out, compare_flag_two_out, timer_irq_out,
  input wire logic [1:0] mode_out,
  input wire logic [W-1:0] compare_value_one_in, compare_value_two_in, counter_out,
  input wire logic [W-1:0] capture_value_two_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire pwm_on = configure_pulse_width_mode_in && timer_enable_in;
  wire hit_two = pwm_on && timer_enable_in && counter_out == compare_value_two_in;
  // value two owns the pin when both match
  wire hit_one = pwm_on && timer_enable_in && counter_out == compare_value_one_in && !hit_two;
  wire arm_two = capture_edge_rising_in && timer_enable_in;
  a_mode_pulse: assert property (pwm_on |=> mode_out == 2'h1)
    else $error("mode not pulse");
  a_cap_two_live: assert property ($rose(capture_input_two_in) && arm_two |->
    ##[1:2] capture_flag_two_out) else $error("capture two missed");
  a_level_one: assert property (hit_one |=>
    compare_output_pin_one_out == $past(match_one_level_high_in)) else $error("pin level one");
  a_level_two: assert property (hit_two |=>
    compare_output_pin_one_out == $past(match_two_level_high_in)) else $error("pin level two");
  a_cmp_flag_quiet: assert property (pwm_on |=> !$rose(compare_flag_one_out) &&
    !$rose(compare_flag_two_out)) else $error("compare flag set");
  a_wrap_restart: assert property (hit_two |=> counter_out == '0)
    else $error("counter kept running");
  a_wrap_flag: assert property (hit_two |=> capture_flag_one_out)
    else $error("capture one flag missing");
  a_wrap_irq: assert property (hit_two && capture_irq_enable_in |=> timer_irq_out)
    else $error("capture irq missing");
  a_cmp_irq_quiet: assert property (pwm_on && !capture_irq_enable_in |=> !timer_irq_out)
    else $error("compare irq raised");
  a_cap_two_value: assert property ($rose(capture_input_two_in) && arm_two |=>
    capture_value_two_out == $past(counter_out)) else $error("capture two value");
  cover property (hit_one && match_one_level_high_in);
  cover property (hit_two && capture_irq_enable_in);
  cover property ($rose(capture_flag_two_out));
endmodule : etp_props
bind etp_timer_pwm etp_props #(.W(W)) u_props (.*);

// *** dv/etp_load.sv ***
`timescale 1ns/1ps
module etp_load (
  input wire logic sys_clk_in,
  input wire logic pin_in,
  output int rises_out = 0
);
  logic last_ff = 1'b0;
  // the load only notices low-to-high swings
  always @(posedge sys_clk_in)
  begin
    rises_out <= rises_out + int'(pin_in && !last_ff);
    last_ff <= pin_in;
  end
endmodule : etp_load

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", n, e, a); end end
module tb_top;
  logic sys_clk_in = 0, reset_n_in = 0, single_pulse_mode_in = 0, flag_clear_in = 0;
  logic configure_pulse_width_mode_in = 1, match_one_level_high_in = 0;
  logic match_two_level_high_in = 0, capture_input_one_in = 0, capture_input_two_in = 0;
  logic capture_edge_rising_in = 1, capture_irq_enable_in = 0;
  logic [7:0] compare_value_one_in = 8'h00, compare_value_two_in = 8'h10;
  logic compare_output_pin_one_out, capture_flag_one_out, capture_flag_two_out;
  logic compare_flag_one_out, compare_flag_two_out, timer_irq_out;
  logic [7:0] counter_out, capture_value_one_out, capture_value_two_out;
  logic [1:0] mode_out;
  int err_count = 0, num_checks = 0, rises, r0, highs, a, b;
  etp_timer_pwm u_dut (.timer_enable_in(1'b1), .compare_irq_enable_in(1'b1), .*);
  etp_load u_load (.sys_clk_in(sys_clk_in), .pin_in(compare_output_pin_one_out), .rises_out(rises));
  function automatic int exp_high(int v1, int v2, bit h1, bit h2);
    // value two wins a tie, and value one above two never matches
    return v1 >= v2 ? h2 * (v2 + 1) : h1 * (v2 - v1) + h2 * (v1 + 1);
  endfunction : exp_high
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial forever #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
  begin
    capture_input_one_in <= 1'($urandom);
    capture_input_two_in <= 1'($urandom);
  end
  initial
  begin
    void'($urandom(32'h12957f59));
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1;
    for (int t = 0; t < 16; t++)
    begin
      @(posedge sys_clk_in);
      b = t == 0 ? 252 : t == 2 ? 0 : $urandom % 253;
      a = t == 0 ? 0 : t == 1 ? b : $urandom % 253;
      compare_value_one_in <= 8'(a);
      compare_value_two_in <= 8'(b);
      {match_one_level_high_in, match_two_level_high_in} <= 2'($urandom);
      {single_pulse_mode_in, capture_irq_enable_in, capture_edge_rising_in} <= 3'($urandom);
      flag_clear_in <= 1;
      repeat (300) @(posedge sys_clk_in);
      flag_clear_in <= 0;
      repeat (2 * b + 4) @(posedge sys_clk_in);
      // sample off the edge so the pin has settled
      @(negedge sys_clk_in);
      r0 = rises;
      highs = 0;
      repeat (b + 1) @(negedge sys_clk_in) highs += compare_output_pin_one_out;
      `CHK("high cycles", exp_high(a, b, match_one_level_high_in, match_two_level_high_in), highs)
      `CHK("rises", r0 + (match_one_level_high_in != match_two_level_high_in && a < b), rises)
      `CHK("compare flags", 2'b00, {compare_flag_one_out, compare_flag_two_out})
      `CHK("irq", capture_irq_enable_in, timer_irq_out)
      `CHK("mode", 2'h1, mode_out)
      `CHK("capture one", 8'h00, capture_value_one_out)
      $display("test %0d done", t);
    end
    @(posedge sys_clk_in);
    configure_pulse_width_mode_in <= 0;
    single_pulse_mode_in <= 1;
    flag_clear_in <= 1;
    @(posedge sys_clk_in);
    flag_clear_in <= 0;
    repeat (300) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    `CHK("mode single", 2'h2, mode_out)
    `CHK("compare flags on", 2'b11, {compare_flag_one_out, compare_flag_two_out})
    `CHK("capture one blocked", 1'b0, capture_flag_one_out)
    `CHK("irq single", 1'b1, timer_irq_out)
    @(posedge sys_clk_in);
    single_pulse_mode_in <= 0;
    flag_clear_in <= 1;
    @(posedge sys_clk_in);
    flag_clear_in <= 0;
    repeat (300) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    `CHK("mode idle", 2'h0, mode_out)
    `CHK("capture one live", 1'b1, capture_flag_one_out)
    $display("test modes done");
    end_sim();
  end
  initial
  begin
    #200us;
    err_count++;
    end_sim();
  end
endmodule : tb_top
